// file: iox_chk.sv
// assertions on the expander's pins
`timescale 1ns/1ns
module iox_chk (
    input wire logic               ref_clk,  // core clock
    input wire logic               reset_n,  // async reset
    input wire logic               sclIn,    // bus clock
    input wire logic               sdaOut,   // data drive
    input wire logic               sdaOe,    // data enable
    input wire iox_pkg::iox_byte_t portIn,   // pins
    input wire iox_pkg::iox_byte_t portOut,  // pin drive
    input wire iox_pkg::iox_byte_t portOe,   // pin enable
    input wire logic               intOut_n, // irq drive
    input wire logic               intOe     // irq enable
);
    import iox_pkg::*;
    iox_byte_t  inPrev_q;
    iox_byte_t  oePrev_q;
    logic [7:0] age_q;
    always_ff @(posedge ref_clk)
    begin
        inPrev_q <= portIn;
        oePrev_q <= portOe;
    end
    // age of the last pin or direction change; nothing else may raise the irq
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            age_q <= 8'hFF;
        else if (portIn != inPrev_q || portOe != oePrev_q)
            age_q <= 8'h00;
        else if (age_q != 8'hFF)
            age_q <= age_q + 8'h01;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence ackHold;
        sdaOe [*8];
    endsequence
    chk_reset_defaults: assert property (
        $rose(reset_n) |-> portOe == 8'h00 && portOut == 8'hFF && !intOe)
        else $error("pins not at defaults after reset");
    chk_int_open_drain: assert property (
        intOe |-> !intOut_n)
        else $error("irq enabled without pulling low");
    chk_sda_open_drain: assert property (
        sdaOe |-> !sdaOut)
        else $error("data enabled without pulling low");
    chk_out_with_ack: assert property (
        $changed(portOut) |-> ##[0:16] sdaOe)
        else $error("output latch moved outside a write");
    chk_dir_with_ack: assert property (
        $changed(portOe) |-> ##[0:16] sdaOe)
        else $error("direction moved outside a write");
    chk_sda_low_scl: assert property (
        $changed(sdaOe) |-> !sclIn)
        else $error("data changed while clock high");
    chk_ack_stands: assert property (
        $rose(sdaOe) |-> ackHold)
        else $error("data drive too short");
    chk_int_cause: assert property (
        $rose(intOe) |-> age_q <= 8'h08)
        else $error("irq raised without a pin change");
endmodule : iox_chk

// file: iox_expander.sv
// eight-pin serial-bus i/o expander: bus slave engine and register file
`timescale 1ns/1ns
module iox_expander (
    input  wire logic               ref_clk,   // 125 MHz core clock
    input  wire logic               reset_n,   // async reset, active low
    input  wire logic               sclIn,     // serial clock pin level
    input  wire logic               sdaIn,     // serial data pin level
    output logic                    sdaOut,    // serial data drive value
    output logic                    sdaOe,     // serial data drive enable
    input  wire logic               addrSel,   // address-select strap
    input  wire iox_pkg::iox_byte_t portIn,    // port pin levels
    output iox_pkg::iox_byte_t      portOut,   // port pin drive values
    output iox_pkg::iox_byte_t      portOe,    // port pin drive enables
    output logic                    intOut_n,  // interrupt drive value
    output logic                    intOe      // interrupt drive enable
);
    import iox_pkg::*;

    // register the current pointer selects on a read
    function automatic iox_byte_t readMux(
        input iox_byte_t ptr,
        input iox_byte_t inVal,
        input iox_byte_t outVal,
        input iox_byte_t polVal,
        input iox_byte_t dirVal
    );
        iox_byte_t r;
        unique case (ptr)
            CMD_INPUT:     r = inVal;
            CMD_OUTPUT:    r = outVal;
            CMD_POLARITY:  r = polVal;
            CMD_DIRECTION: r = dirVal;
            default:       r = UNMAPPED_READ;
        endcase
        return r;
    endfunction : readMux

    iox_port_if pio ();

    logic       sclF;
    logic       sdaF;
    logic       addrF;
    logic       sclPrevQ;
    logic       sdaPrevQ;

    iox_state_e stateQ;
    iox_state_e stateD;
    logic [3:0] bitCntQ;
    logic [3:0] bitCntD;
    iox_byte_t  shiftQ;
    iox_byte_t  shiftD;
    iox_byte_t  txQ;
    iox_byte_t  txD;
    iox_byte_t  ptrQ;
    iox_byte_t  ptrD;
    logic       rwQ;
    logic       rwD;
    logic       ackedQ;
    logic       ackedD;
    logic       sdaOeD;
    logic       wrStrobe;
    logic       captureD;

    iox_byte_t  outLatchQ;
    iox_byte_t  polInvQ;
    iox_byte_t  dirQ;

    // the strap is assumed static; it passes the same filter as the bus
    iox_sync #(
        .W    (3),
        .RST  (3'h7),
        .FILT (GLITCH_CYC)
    ) u_bus_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .rawIn   ({sclIn, sdaIn, addrSel}),
        .clean   ({sclF, sdaF, addrF})
    );

    iox_port_bank u_bank (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .portIn  (portIn),
        .pb      (pio.bank)
    );

    assign pio.invert  = polInvQ;
    assign pio.dirIn   = dirQ;
    assign pio.capture = captureD;

    // bus events, taken from filtered levels only
    wire sclRise   = sclF && !sclPrevQ;
    wire sclFall   = !sclF && sclPrevQ;
    wire startCond = sclF && sclPrevQ && sdaPrevQ && !sdaF;
    wire stopCond  = sclF && sclPrevQ && !sdaPrevQ && sdaF;
    wire byteDone  = bitCntQ == BITS_PER_BYTE;
    wire addrHit   = shiftQ[7:1] == {ADDR_BASE, addrF};
    wire shifting  = stateQ == ST_ADDR || stateQ == ST_CMD || stateQ == ST_WDATA;

    wire iox_byte_t readVal = readMux(ptrQ, pio.liveValue, outLatchQ,
                                      polInvQ, dirQ);
    wire ptrIsInput = ptrQ == CMD_INPUT;

    wire wrOut = wrStrobe && ptrQ == CMD_OUTPUT;
    wire wrPol = wrStrobe && ptrQ == CMD_POLARITY;
    wire wrDir = wrStrobe && ptrQ == CMD_DIRECTION;

    // protocol engine; bit timing relies only on edges, so any rate up to
    // 400 kHz leaves over 150 core cycles per phase
    always_comb
    begin
        stateD   = stateQ;
        bitCntD  = bitCntQ;
        shiftD   = shiftQ;
        txD      = txQ;
        ptrD     = ptrQ;
        rwD      = rwQ;
        ackedD   = ackedQ;
        sdaOeD   = sdaOe;
        wrStrobe = 1'b0;
        captureD = 1'b0;
        if (startCond)
        begin
            stateD  = ST_ADDR;
            bitCntD = '0;
            sdaOeD  = 1'b0;
        end
        else if (stopCond)
        begin
            stateD = ST_IDLE;
            sdaOeD = 1'b0;
        end
        else if (sclRise)
        begin
            if (stateQ == ST_RACK)
                ackedD = !sdaF;
            else if (shifting && !byteDone)
            begin
                shiftD  = {shiftQ[6:0], sdaF};
                bitCntD = bitCntQ + 4'h1;
            end
            else if (stateQ == ST_RDATA && !byteDone)
                bitCntD = bitCntQ + 4'h1;
        end
        else if (sclFall)
        begin
            unique case (stateQ)
                ST_IDLE:
                    sdaOeD = 1'b0;
                ST_ADDR:
                    if (byteDone)
                    begin
                        if (addrHit)
                        begin
                            rwD    = shiftQ[0];
                            sdaOeD = 1'b1;
                            stateD = ST_ADDR_ACK;
                        end
                        else
                            stateD = ST_IDLE;
                    end
                ST_ADDR_ACK:
                begin
                    bitCntD = '0;
                    if (rwQ)
                    begin
                        txD      = readVal;
                        captureD = ptrIsInput;
                        sdaOeD   = !readVal[7];
                        stateD   = ST_RDATA;
                    end
                    else
                    begin
                        sdaOeD = 1'b0;
                        stateD = ST_CMD;
                    end
                end
                ST_CMD:
                    if (byteDone)
                    begin
                        ptrD   = shiftQ;
                        sdaOeD = 1'b1;
                        stateD = ST_CMD_ACK;
                    end
                ST_CMD_ACK, ST_WDATA_ACK:
                begin
                    sdaOeD  = 1'b0;
                    bitCntD = '0;
                    stateD  = ST_WDATA;
                end
                ST_WDATA:
                    if (byteDone)
                    begin
                        wrStrobe = 1'b1;
                        sdaOeD   = 1'b1;
                        stateD   = ST_WDATA_ACK;
                    end
                ST_RDATA:
                    if (byteDone)
                    begin
                        sdaOeD = 1'b0;
                        stateD = ST_RACK;
                    end
                    else
                        sdaOeD = !txQ[3'(4'h7 - bitCntQ)];
                ST_RACK:
                    if (ackedQ)
                    begin
                        txD      = readVal;
                        captureD = ptrIsInput;
                        sdaOeD   = !readVal[7];
                        bitCntD  = '0;
                        stateD   = ST_RDATA;
                    end
                    else
                    begin
                        sdaOeD = 1'b0;
                        stateD = ST_IDLE;
                    end
            endcase
        end
    end

    // bus engine state; reset pin and power-on share this path
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stateQ   <= ST_IDLE;
            bitCntQ  <= '0;
            shiftQ   <= '0;
            txQ      <= '0;
            ptrQ     <= PTR_RST;
            rwQ      <= 1'b0;
            ackedQ   <= 1'b0;
            sdaOe    <= 1'b0;
            sclPrevQ <= 1'b1;
            sdaPrevQ <= 1'b1;
        end
        else
        begin
            stateQ   <= stateD;
            bitCntQ  <= bitCntD;
            shiftQ   <= shiftD;
            txQ      <= txD;
            ptrQ     <= ptrD;
            rwQ      <= rwD;
            ackedQ   <= ackedD;
            sdaOe    <= sdaOeD;
            sclPrevQ <= sclF;
            sdaPrevQ <= sdaF;
        end
    end

    // register file; writes to the input register or unmapped codes are lost
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outLatchQ <= OUT_RST;
            polInvQ   <= POL_RST;
            dirQ      <= DIR_RST;
        end
        else
        begin
            if (wrOut)
                outLatchQ <= shiftQ;
            if (wrPol)
                polInvQ <= shiftQ;
            if (wrDir)
                dirQ <= shiftQ;
        end
    end

    // pin drivers: enable is the inverse of the direction bit
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            portOut  <= OUT_RST;
            portOe   <= ~DIR_RST;
            intOe    <= 1'b0;
            intOut_n <= 1'b0;
            sdaOut   <= 1'b0;
        end
        else
        begin
            portOut  <= wrOut ? shiftQ : outLatchQ;
            portOe   <= wrDir ? ~shiftQ : ~dirQ;
            intOe    <= pio.intReq;
            intOut_n <= 1'b0;
            sdaOut   <= 1'b0;
        end
    end
endmodule : iox_expander

// file: iox_i2c_master.sv
// bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/1ns
module iox_i2c_master (
    input  wire logic sdaLine, // resolved data wire
    output logic      sclOut,  // clock line
    output logic      sdaLow   // pulls data low
);
    logic lclk;
    logic r;
    // tick sits 3 ns off core edges; clock stays high between frames
    initial
    begin
        lclk = 1'b0;
        sclOut = 1'b1;
        sdaLow = 1'b0;
        #3;
        forever #40 lclk = ~lclk;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge lclk);
    endtask : tk
    // data moves while the clock is low, read back at mid-high
    task automatic bitx(input logic b, output logic s);
        tk(1);
        sdaLow <= !b;
        tk(2);
        sclOut <= 1'b1;
        tk(2);
        s = sdaLine;
        tk(1);
        sclOut <= 1'b0;
    endtask : bitx
    // also serves as repeated start when the clock is low
    task automatic start;
        tk(1);
        sdaLow <= 1'b0;
        tk(2);
        sclOut <= 1'b1;
        tk(2);
        sdaLow <= 1'b1;
        tk(2);
        sclOut <= 1'b0;
    endtask : start
    task automatic stop;
        tk(1);
        sdaLow <= 1'b1;
        tk(2);
        sclOut <= 1'b1;
        tk(2);
        sdaLow <= 1'b0;
        tk(2);
    endtask : stop
    task automatic wrByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask : wrByte
    task automatic rdByte(input logic mAck, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(!mAck, r);
    endtask : rdByte
    // a 24 ns clock spike in mid-low must not count as a bit; it sits clear
    // of the slave's ack release so data never moves with the clock high
    task automatic glitch;
        tk(1);
        #40;
        sclOut <= 1'b1;
        #24;
        sclOut <= 1'b0;
    endtask : glitch
endmodule : iox_i2c_master

// file: iox_pkg.sv
// shared constants, command codes and types for the i/o expander
package iox_pkg;

    localparam int CLK_MHZ = 125;
    // spikes on scl/sda shorter than this never reach the protocol engine
    localparam int GLITCH_NS = 50;
    localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int PIN_FILT_CYC = 1;
    // pin captures follow the synchroniser until its reset value is flushed
    localparam logic [2:0] PIN_SETTLE_CYC = 3'h5;
    localparam int BUS_MAX_KHZ = 400;

    localparam int PORT_W = 8;
    localparam logic [5:0] ADDR_BASE = 6'h10;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    localparam logic [7:0] CMD_INPUT = 8'h00;
    localparam logic [7:0] CMD_OUTPUT = 8'h01;
    localparam logic [7:0] CMD_POLARITY = 8'h02;
    localparam logic [7:0] CMD_DIRECTION = 8'h03;

    localparam logic [7:0] OUT_RST = 8'hFF;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef logic [PORT_W-1:0] iox_byte_t;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_CMD,
        ST_CMD_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK
    } iox_state_e;

endpackage : iox_pkg

// file: iox_port_bank.sv
// port pin sampling, input capture, polarity and change detection
`timescale 1ns/1ns
module iox_port_bank (
    input  wire logic              ref_clk, // core clock
    input  wire logic              reset_n, // async reset, active low
    input  wire iox_pkg::iox_byte_t portIn, // raw port pin levels
    iox_port_if.bank               pb       // link to the bus engine
);
    import iox_pkg::*;

    iox_byte_t  pinLevel;
    iox_byte_t  capturedQ;
    logic [2:0] primeCntQ;
    logic       intReqQ;

    iox_sync #(
        .W    (PORT_W),
        .RST  (OUT_RST),
        .FILT (PIN_FILT_CYC)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .rawIn   (portIn),
        .clean   (pinLevel)
    );

    wire iox_byte_t mismatch = (pinLevel ^ capturedQ) & pb.dirIn;
    wire            primed   = primeCntQ == PIN_SETTLE_CYC;

    assign pb.liveValue = pinLevel ^ pb.invert;
    assign pb.heldValue = capturedQ ^ pb.invert;
    assign pb.intReq    = intReqQ;

    // captures track the pins until the synchroniser has flushed its reset
    // value; an earlier capture would flag a change that never happened
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            capturedQ <= '0;
            primeCntQ <= '0;
            intReqQ   <= 1'b0;
        end
        else
        begin
            if (!primed)
                primeCntQ <= primeCntQ + 3'h1;
            if (!primed || pb.capture)
                capturedQ <= pinLevel;
            intReqQ <= primed && !pb.capture && (|mismatch);
        end
    end
endmodule : iox_port_bank

// file: iox_port_if.sv
// signals between the bus engine and the port pin bank
`timescale 1ns/1ns
interface iox_port_if;
    import iox_pkg::*;

    iox_byte_t invert;
    iox_byte_t dirIn;
    logic      capture;
    iox_byte_t liveValue;
    iox_byte_t heldValue;
    logic      intReq;

    modport bank (
        input  invert,
        input  dirIn,
        input  capture,
        output liveValue,
        output heldValue,
        output intReq
    );

    modport ctrl (
        output invert,
        output dirIn,
        output capture,
        input  liveValue,
        input  heldValue,
        input  intReq
    );
endinterface : iox_port_if

// file: iox_sync.sv
// three-stage synchroniser with an agreement filter, one per bit
`timescale 1ns/1ns
module iox_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] RST  = '0,
    parameter int           FILT = 1
) (
    input  wire logic         ref_clk, // core clock
    input  wire logic         reset_n, // async reset, active low
    input  wire logic [W-1:0] rawIn,   // asynchronous inputs
    output logic      [W-1:0] clean    // filtered, synchronous levels
);
    localparam int CW = $clog2(FILT + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(FILT - 1);

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic          s1Q;
            logic          s2Q;
            logic          s3Q;
            logic [CW-1:0] cntQ;
            wire           differs = (s2Q == s3Q) && (s3Q != clean[i]);

            always_ff @(posedge ref_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    s1Q      <= RST[i];
                    s2Q      <= RST[i];
                    s3Q      <= RST[i];
                    cntQ     <= '0;
                    clean[i] <= RST[i];
                end
                else
                begin
                    s1Q <= rawIn[i];
                    s2Q <= s1Q;
                    s3Q <= s2Q;
                    // a level must agree for FILT cycles before it is taken
                    if (!differs)
                        cntQ <= '0;
                    else if (cntQ == CNT_LAST)
                    begin
                        cntQ     <= '0;
                        clean[i] <= s3Q;
                    end
                    else
                        cntQ <= cntQ + CW'(1);
                end
            end
        end
    endgenerate
endmodule : iox_sync

// file: testbench.sv
// self-checking bench for the i/o expander
`timescale 1ns/1ns
module testbench;
    import iox_pkg::*;
    typedef struct {
        string     nm;
        iox_byte_t v;
    } iox_note_s;
    logic      ref_clk = 1'b0;
    logic      reset_n = 1'b0;
    logic      addrSel = 1'b0;
    iox_byte_t extIn   = 8'h00;
    iox_byte_t seen, pol, v, d, capVal;
    logic      sclIn, sdaLow, sdaOut, sdaOe, intOut_n, intOe, ack;
    iox_byte_t portOut, portOe;
    iox_note_s noteQ[$];
    iox_note_s note;
    int        failures    = 0;
    int        check_count = 0;
    int        cycles      = 0;
    event      gotEv;
    // pulled-up data wire; pins show the drive where enabled
    wire            sdaLine = !(sdaOe || sdaLow);
    wire iox_byte_t pinLvl  = (portOe & portOut) | (~portOe & extIn);
    iox_expander iox_expander_inst (.ref_clk(ref_clk), .reset_n(reset_n), .sclIn(sclIn),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel), .portIn(pinLvl),
        .portOut(portOut), .portOe(portOe), .intOut_n(intOut_n), .intOe(intOe));
    iox_i2c_master iox_i2c_master_inst (.sdaLine(sdaLine), .sclOut(sclIn), .sdaLow(sdaLow));
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            failures++;
            final_report();
        end
    end
    always @(gotEv)
    begin
        note = noteQ.pop_front();
        check(note.nm, seen, note.v);
    end
    task automatic check(input string nm, input iox_byte_t s, input iox_byte_t e);
        check_count++;
        if (s !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            failures++;
        end
    endtask : check
    task automatic expect_v(input string nm, input iox_byte_t e);
        noteQ.push_back('{nm, e});
    endtask : expect_v
    task automatic give(input iox_byte_t s);
        seen = s;
        -> gotEv;
        #1;
    endtask : give
    task automatic see(input string nm, input iox_byte_t s, input iox_byte_t e);
        expect_v(nm, e);
        give(s);
    endtask : see
    task automatic send(input iox_byte_t b, input logic e);
        expect_v("ack", {7'h00, e});
        iox_i2c_master_inst.wrByte(b, ack);
        give({7'h00, ack});
    endtask : send
    task automatic regWr(input iox_byte_t c, input iox_byte_t w);
        iox_i2c_master_inst.start();
        send({6'b010000, addrSel, 1'b0}, 1'b1);
        send(c, 1'b1);
        send(w, 1'b1);
        iox_i2c_master_inst.stop();
    endtask : regWr
    task automatic regRd(input iox_byte_t c, input iox_byte_t e);
        iox_byte_t r;
        iox_i2c_master_inst.start();
        send({6'b010000, addrSel, 1'b0}, 1'b1);
        send(c, 1'b1);
        iox_i2c_master_inst.start();
        send({6'b010000, addrSel, 1'b1}, 1'b1);
        expect_v("read", e);
        iox_i2c_master_inst.rdByte(1'b0, r);
        give(r);
        iox_i2c_master_inst.stop();
    endtask : regRd
    task automatic final_report;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    initial
    begin
        void'($urandom(32'h899B));
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        see("oe", portOe, 8'h00);
        see("out", portOut, 8'hFF);
        regRd(CMD_OUTPUT, 8'hFF);
        regRd(CMD_POLARITY, 8'h00);
        regRd(CMD_DIRECTION, 8'hFF);
        // flip the strap: the old address must go unanswered
        addrSel <= 1'b1;
        repeat (20) @(posedge ref_clk);
        iox_i2c_master_inst.start();
        send(8'h40, 1'b0);
        iox_i2c_master_inst.stop();
        repeat (2)
        begin
            d = $urandom();
            v = $urandom();
            regWr(CMD_DIRECTION, d);
            regWr(CMD_OUTPUT, v);
            see("oe", portOe, ~d);
            see("out", portOut, v);
            regRd(CMD_DIRECTION, d);
            regRd(CMD_OUTPUT, v);
        end
        regWr(CMD_DIRECTION, 8'hFF);
        capVal = 8'h00;
        repeat (2)
        begin
            pol = $urandom();
            v = $urandom();
            regWr(CMD_POLARITY, pol);
            extIn <= v;
            repeat (12) @(posedge ref_clk);
            see("irq", {7'h00, intOe}, {7'h00, v != capVal});
            regRd(CMD_INPUT, v ^ pol);
            capVal = v;
            see("irq", {7'h00, intOe}, 8'h00);
        end
        extIn <= capVal ^ 8'h80;
        repeat (12) @(posedge ref_clk);
        see("irq", {7'h00, intOe}, 8'h01);
        extIn <= capVal;
        repeat (12) @(posedge ref_clk);
        see("irq", {7'h00, intOe}, 8'h00);
        // two data bytes in one write land in the same register
        iox_i2c_master_inst.start();
        send(8'h42, 1'b1);
        send(CMD_OUTPUT, 1'b1);
        send(8'h3C, 1'b1);
        send(8'hC3, 1'b1);
        iox_i2c_master_inst.stop();
        regRd(CMD_POLARITY, pol);
        regRd(8'h07, 8'h00);
        regWr(CMD_DIRECTION, 8'h00);
        see("pins", pinLvl, 8'hC3);
        // a spike inside a write would shift a stray bit into the data byte
        iox_i2c_master_inst.start();
        send(8'h42, 1'b1);
        send(CMD_OUTPUT, 1'b1);
        iox_i2c_master_inst.glitch();
        send(8'h5A, 1'b1);
        iox_i2c_master_inst.stop();
        regWr(CMD_INPUT, 8'hA5);
        regRd(CMD_OUTPUT, 8'h5A);
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        see("oe", portOe, 8'h00);
        see("out", portOut, 8'hFF);
        reset_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        regRd(CMD_DIRECTION, 8'hFF);
        final_report();
    end
endmodule : testbench
bind iox_expander iox_chk iox_chk_inst (.ref_clk(ref_clk), .reset_n(reset_n), .sclIn(sclIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .portIn(portIn), .portOut(portOut), .portOe(portOe),
    .intOut_n(intOut_n), .intOe(intOe));
